// [rtl/current_fault_response_ctrl.sv]
// Fault thresholds and under-current fault response of a digitally managed converter.
`timescale 1ns/10ps
`include "current_fault_response_ctrl_params.svh"
module current_fault_response_ctrl
  import current_fault_response_ctrl_pkg::*;
#(
  parameter logic [`TIMER_W-1:0] CONT_UNIT_CYCLES  = `TIMER_W'(`CONT_UNIT_CYCLES),
  parameter logic [`TIMER_W-1:0] RETRY_UNIT_CYCLES = `TIMER_W'(`RETRY_UNIT_CYCLES)
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Decoded command port from the host interface
  input  wire logic        i_cmd_wr,
  input  wire logic        i_cmd_rd,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [15:0] i_cmd_wdata,
  input  wire logic        i_clear_faults,
  output logic [15:0]      o_cmd_rdata,
  output logic             o_cmd_rvalid,
  output logic             o_cmd_nack,
  // Measurements
  input  wire logic        i_meas_valid,
  input  wire logic [15:0] i_iout_meas,
  input  wire logic [15:0] i_temp_meas,
  // On/off control
  input  wire logic        i_ctrl_pin,
  input  wire logic        i_operation_on,
  input  wire logic        i_other_fault_shutdown,
  // Power stage and status
  output logic             o_output_enable,
  output logic             o_uc_fault_status,
  output logic             o_oc_warn_status,
  output logic             o_ot_fault_status,
  // Open-drain alert line
  output logic             o_alert_line_n_out,
  output logic             o_alert_line_n_oe
);
  ctrl_state_t          c_reg;
  ctrl_state_t          c_next;
  logic                 timer_start;
  logic [`TIMER_W-1:0]  timer_unit_cycles;
  logic                 timer_busy;
  logic                 timer_done;

  // Turns a linear word (5-bit exponent, 11-bit mantissa) into a value scaled by 2^16.
  function automatic logic signed [47:0] lin_value(input logic [15:0] w);
    logic signed [47:0] m;
    logic [5:0]         sh;
    m = {{37{w[10]}}, w[10:0]};
    sh = {w[15], w[15:11]} + 6'h10;
    lin_value = m <<< sh;
  endfunction : lin_value

  fault_delay_timer u_timer (
    .i_mclk        (i_mclk),
    .i_rst         (i_rst),
    .i_start       (timer_start),
    .i_unit_cycles (timer_unit_cycles),
    .i_units       (c_reg.uc_action[`ACT_DELAY_HI:`ACT_DELAY_LO]),
    .o_busy        (timer_busy),
    .o_done        (timer_done)
  );

  always_comb begin
    logic [1:0] resp;
    logic [2:0] retries;
    logic       on_cmd;
    logic       below;
    logic       uc_evt;
    logic       go_retry;
    logic       set_uc;
    logic       set_oc;
    logic       set_ot;
    logic       clr;
    c_next = c_reg;
    resp = c_reg.uc_action[`ACT_RESP_HI:`ACT_RESP_LO];
    retries = c_reg.uc_action[`ACT_RETRY_HI:`ACT_RETRY_LO];
    on_cmd = i_operation_on & c_reg.ctrl_s2;
    below = lin_value(i_iout_meas) < lin_value(c_reg.uc_thr);
    uc_evt = 1'b0;
    go_retry = 1'b0;
    clr = 1'b0;
    set_uc = 1'b0;
    set_oc = 1'b0;
    set_ot = 1'b0;
    timer_start = 1'b0;
    // A running timer reloads each later unit with the length that belongs to its own wait.
    timer_unit_cycles = RETRY_UNIT_CYCLES;
    if (c_reg.state == ST_DELAY) begin
      timer_unit_cycles = CONT_UNIT_CYCLES;
    end
    c_next.rd_valid = 1'b0;
    c_next.cmd_nack = 1'b0;

    c_next.ctrl_s1 = i_ctrl_pin;
    c_next.ctrl_s2 = c_reg.ctrl_s1;
    c_next.on_prev = on_cmd;

    if (i_cmd_wr) begin
      case (i_cmd_code)
        `CMD_OC_WARN_THR:  c_next.oc_warn_thr = i_cmd_wdata;
        `CMD_UC_FAULT_THR: c_next.uc_thr = i_cmd_wdata;
        `CMD_UC_ACTION:    c_next.uc_action = i_cmd_wdata[7:0];
        `CMD_OT_FAULT_THR: c_next.ot_thr = i_cmd_wdata;
        default:           c_next.cmd_nack = 1'b1;
      endcase
    end
    if (i_cmd_rd) begin
      c_next.rd_valid = 1'b1;
      case (i_cmd_code)
        `CMD_OC_WARN_THR:  c_next.rd_data = c_reg.oc_warn_thr;
        `CMD_UC_FAULT_THR: c_next.rd_data = c_reg.uc_thr;
        `CMD_UC_ACTION:    c_next.rd_data = {8'h00, c_reg.uc_action};
        `CMD_OT_FAULT_THR: c_next.rd_data = c_reg.ot_thr;
        default: begin
          c_next.rd_data = 16'h0000;
          c_next.cmd_nack = 1'b1;
        end
      endcase
    end

    if (i_meas_valid) begin
      c_next.uc_active = below;
    end

    case (c_reg.state)
      ST_RUN: begin
        if (i_meas_valid && below && c_reg.out_en) begin
          uc_evt = 1'b1;
          case (resp)
            `RESP_IGNORE: c_next.state = ST_RUN;
            `RESP_DELAY_THEN_RETRY: begin
              timer_start = 1'b1;
              timer_unit_cycles = CONT_UNIT_CYCLES;
              c_next.state = ST_DELAY;
            end
            `RESP_DISABLE_RETRY: go_retry = 1'b1;
            default: c_next.state = ST_HOLD;
          endcase
        end else if (i_meas_valid && !below) begin
          // A clean measurement ends the episode, so the next fault counts from zero.
          c_next.retry_cnt = 3'h0;
        end
      end
      ST_DELAY: begin
        if (timer_done) begin
          if (c_reg.uc_active) begin
            go_retry = 1'b1;
          end else begin
            c_next.state = ST_RUN;
          end
        end
      end
      ST_WAIT: begin
        if (timer_done) begin
          c_next.retry_cnt = c_reg.retry_cnt + 3'h1;
          c_next.state = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (i_meas_valid && !below) begin
          c_next.state = ST_RUN;
        end
      end
      ST_LATCHED: c_next.state = ST_LATCHED;
      default: c_next.state = ST_RUN;
    endcase

    if (go_retry) begin
      if (retries == `RETRY_NONE) begin
        c_next.state = ST_LATCHED;
      end else if (retries != `RETRY_ENDLESS && c_reg.retry_cnt >= retries) begin
        c_next.state = ST_LATCHED;
      end else begin
        timer_start = 1'b1;
        timer_unit_cycles = RETRY_UNIT_CYCLES;
        c_next.state = ST_WAIT;
      end
    end

    clr = i_clear_faults | (on_cmd & ~c_reg.on_prev);
    if (clr && c_next.state != ST_WAIT) begin
      c_next.state = ST_RUN;
      c_next.retry_cnt = 3'h0;
    end
    if (i_other_fault_shutdown) begin
      c_next.state = ST_LATCHED;
    end
    if (!on_cmd) begin
      c_next.state = ST_RUN;
      c_next.retry_cnt = 3'h0;
    end

    set_uc = uc_evt;
    set_oc = i_meas_valid && (lin_value(i_iout_meas) > lin_value(c_reg.oc_warn_thr));
    set_ot = i_meas_valid && (lin_value(i_temp_meas) > lin_value(c_reg.ot_thr));
    // A new event in the clearing cycle keeps its bit set.
    c_next.uc_stat = set_uc | (c_reg.uc_stat & ~clr);
    c_next.oc_stat = set_oc | (c_reg.oc_stat & ~clr);
    c_next.ot_stat = set_ot | (c_reg.ot_stat & ~clr);
    c_next.alert_oe = c_next.uc_stat | c_next.oc_stat | c_next.ot_stat;

    c_next.out_en = on_cmd && (c_next.state == ST_RUN || c_next.state == ST_DELAY);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      c_reg <= '0;
      c_reg.oc_warn_thr <= `RST_OC_WARN_THR;
      c_reg.uc_thr <= `RST_UC_FAULT_THR;
      c_reg.uc_action <= `RST_UC_ACTION;
      c_reg.ot_thr <= `RST_OT_FAULT_THR;
      c_reg.state <= ST_RUN;
    end else begin
      c_reg <= c_next;
    end
  end

  assign o_cmd_rdata = c_reg.rd_data;
  assign o_cmd_rvalid = c_reg.rd_valid;
  assign o_cmd_nack = c_reg.cmd_nack;
  assign o_output_enable = c_reg.out_en;
  assign o_uc_fault_status = c_reg.uc_stat;
  assign o_oc_warn_status = c_reg.oc_stat;
  assign o_ot_fault_status = c_reg.ot_stat;
  assign o_alert_line_n_out = 1'b0;
  assign o_alert_line_n_oe = c_reg.alert_oe;
endmodule : current_fault_response_ctrl

// [rtl/current_fault_response_ctrl_params.svh]
// Command codes, field positions, reset values and timing counts of the fault response block.
`ifndef CURRENT_FAULT_RESPONSE_CTRL_PARAMS_SVH
`define CURRENT_FAULT_RESPONSE_CTRL_PARAMS_SVH

`define CMD_OC_WARN_THR       8'h4A
`define CMD_UC_FAULT_THR      8'h4B
`define CMD_UC_ACTION         8'h4C
`define CMD_OT_FAULT_THR      8'h4F

`define ACT_RESP_HI           7
`define ACT_RESP_LO           6
`define ACT_RETRY_HI          5
`define ACT_RETRY_LO          3
`define ACT_DELAY_HI          2
`define ACT_DELAY_LO          0

`define RESP_IGNORE           2'h0
`define RESP_DELAY_THEN_RETRY 2'h1
`define RESP_DISABLE_RETRY    2'h2
`define RESP_DISABLE_HOLD     2'h3
`define RETRY_NONE            3'h0
`define RETRY_ENDLESS         3'h7

`define RST_OC_WARN_THR       16'h0000
`define RST_UC_FAULT_THR      16'h0000
`define RST_UC_ACTION         8'h00
`define RST_OT_FAULT_THR      16'h7FFF

// Clock rate in kHz and delay units in microseconds (10 ms and 8.2 ms).
`define CLK_FREQ_KHZ          50000
`define CONT_UNIT_US          10000
`define RETRY_UNIT_US         8200
`define CONT_UNIT_CYCLES      ((`CONT_UNIT_US * `CLK_FREQ_KHZ) / 1000)
`define RETRY_UNIT_CYCLES     ((`RETRY_UNIT_US * `CLK_FREQ_KHZ) / 1000)
`define TIMER_W               24

`endif

// [rtl/current_fault_response_ctrl_pkg.sv]
// Types shared by the fault response controller and its delay timer.
package current_fault_response_ctrl_pkg;
  `include "current_fault_response_ctrl_params.svh"

  typedef enum logic [4:0] {
    ST_RUN     = 5'h01,
    ST_DELAY   = 5'h02,
    ST_WAIT    = 5'h04,
    ST_HOLD    = 5'h08,
    ST_LATCHED = 5'h10
  } uc_state_t;

  typedef struct packed {
    logic [`TIMER_W-1:0] cyc;
    logic [2:0]          units;
    logic                busy;
    logic                done;
  } timer_state_t;

  typedef struct packed {
    logic [15:0] oc_warn_thr;
    logic [15:0] uc_thr;
    logic [7:0]  uc_action;
    logic [15:0] ot_thr;
    uc_state_t   state;
    logic        uc_active;
    logic [2:0]  retry_cnt;
    logic        out_en;
    logic        uc_stat;
    logic        oc_stat;
    logic        ot_stat;
    logic        alert_oe;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        cmd_nack;
    logic        ctrl_s1;
    logic        ctrl_s2;
    logic        on_prev;
  } ctrl_state_t;
endpackage : current_fault_response_ctrl_pkg

// [rtl/fault_delay_timer.sv]
// Counts a number of delay units, each a given number of clock cycles long.
`timescale 1ns/10ps
`include "current_fault_response_ctrl_params.svh"
module fault_delay_timer
  import current_fault_response_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  // Control
  input  wire logic                i_start,
  input  wire logic [`TIMER_W-1:0] i_unit_cycles,
  input  wire logic [2:0]          i_units,
  // Status
  output logic                     o_busy,
  output logic                     o_done
);
  timer_state_t t_reg;
  timer_state_t t_next;

  always_comb begin
    t_next = t_reg;
    t_next.done = 1'b0;
    if (i_start) begin
      t_next.cyc = i_unit_cycles - `TIMER_W'(1);
      t_next.units = i_units;
      // A count of zero units expires on the next edge.
      t_next.busy = (i_units != 3'h0);
      t_next.done = (i_units == 3'h0);
    end else if (t_reg.busy) begin
      if (t_reg.cyc == `TIMER_W'(0)) begin
        if (t_reg.units == 3'h1) begin
          t_next.busy = 1'b0;
          t_next.done = 1'b1;
        end else begin
          t_next.units = t_reg.units - 3'h1;
          t_next.cyc = i_unit_cycles - `TIMER_W'(1);
        end
      end else begin
        t_next.cyc = t_reg.cyc - `TIMER_W'(1);
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign o_busy = t_reg.busy;
  assign o_done = t_reg.done;
endmodule : fault_delay_timer

// [tb/current_fault_response_ctrl_assertions.sv]
// Concurrent checks on the ports of the fault response controller.
`timescale 1ns/10ps
module current_fault_response_ctrl_checker (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst,
  // Command port
  input wire logic        i_cmd_wr,
  input wire logic        i_cmd_rd,
  input wire logic [7:0]  i_cmd_code,
  input wire logic        i_clear_faults,
  input wire logic [15:0] o_cmd_rdata,
  input wire logic        o_cmd_rvalid,
  input wire logic        o_cmd_nack,
  // Faults and output control
  input wire logic        i_meas_valid,
  input wire logic        i_operation_on,
  input wire logic        i_other_fault_shutdown,
  input wire logic        o_output_enable,
  input wire logic        o_uc_fault_status,
  input wire logic        o_oc_warn_status,
  input wire logic        o_ot_fault_status,
  input wire logic        o_alert_line_n_out,
  input wire logic        o_alert_line_n_oe
);
  logic known;
  logic any_stat;
  assign known = i_cmd_code inside {8'h4A, 8'h4B, 8'h4C, 8'h4F};
  assign any_stat = o_uc_fault_status | o_oc_warn_status | o_ot_fault_status;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  alert_low_a: assert property (!o_alert_line_n_out)
    else $error("alert drive value not low");
  alert_or_a: assert property (o_alert_line_n_oe == any_stat)
    else $error("alert does not follow status bits");
  read_ans_a: assert property (i_cmd_rd && known |=> o_cmd_rvalid && !o_cmd_nack)
    else $error("read of a threshold not answered");
  bad_code_a: assert property ((i_cmd_wr || i_cmd_rd) && !known |=> o_cmd_nack)
    else $error("unknown code not refused");
  rdata_hold_a: assert property (!o_cmd_rvalid && !o_cmd_nack |-> $stable(o_cmd_rdata))
    else $error("read data moved without an answer");
  uc_cause_a: assert property ($rose(o_uc_fault_status) |-> $past(i_meas_valid))
    else $error("under-current flag without a measurement");
  ot_cause_a: assert property ($rose(o_ot_fault_status) |-> $past(i_meas_valid))
    else $error("temperature flag without a measurement");
  clear_all_a: assert property (i_clear_faults && !i_meas_valid |=> !any_stat)
    else $error("clear left a status bit set");
  op_off_a: assert property (!i_operation_on [*2] |=> !o_output_enable)
    else $error("output on while commanded off");
  shut_off_a: assert property (i_other_fault_shutdown |=> !o_output_enable)
    else $error("output on after shutdown fault");
  cover property (i_meas_valid ##1 $rose(o_uc_fault_status));
  cover property ($rose(o_output_enable));
  cover property (i_cmd_rd ##1 o_cmd_nack);
endmodule : current_fault_response_ctrl_checker
bind current_fault_response_ctrl current_fault_response_ctrl_checker u_chk (.*);

// [tb/host_cmd_model.sv]
// Host controller model issuing register commands and clear-faults requests.
`timescale 1ns/10ps
module host_cmd_model (
  // Clock
  input  wire logic   i_mclk,
  // Command strobes and payload
  output logic        o_wr,
  output logic        o_rd,
  output logic [7:0]  o_code,
  output logic [15:0] o_wdata,
  output logic        o_clr
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_code = 8'hFF;
    o_wdata = 16'hFFFF;
    o_clr = 1'b0;
  end
  // Released payload is inverted so a stale value never passes for a request.
  task xfer(input logic w, input logic r, input logic [7:0] c, input logic [15:0] d);
    @(negedge i_mclk);
    o_wr = w;
    o_rd = r;
    o_code = c;
    o_wdata = d;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_code = ~c;
    o_wdata = ~d;
  endtask : xfer
  task clear();
    @(negedge i_mclk);
    o_clr = 1'b1;
    @(negedge i_mclk);
    o_clr = 1'b0;
  endtask : clear
endmodule : host_cmd_model

// [tb/current_fault_response_ctrl_tb_top.sv]
// Self-checking bench of the fault response controller.
`timescale 1ns/10ps
module current_fault_response_ctrl_tb_top;
  typedef struct {
    logic [7:0]  c;
    logic [15:0] d;
    logic [15:0] q;
    logic        n;
  } row_t;
  localparam int CU = 10;
  localparam int RU = 8;
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_meas_valid = 1'b0;
  logic [15:0] i_iout_meas = 16'h0000;
  logic [15:0] i_temp_meas = 16'h0000;
  logic        i_ctrl_pin = 1'b1;
  logic        i_operation_on = 1'b1;
  logic        i_other_fault_shutdown = 1'b0;
  logic        i_cmd_wr, i_cmd_rd, i_clear_faults, o_cmd_rvalid, o_cmd_nack;
  logic [7:0]  i_cmd_code;
  logic [15:0] i_cmd_wdata, o_cmd_rdata;
  logic        o_output_enable, o_uc_fault_status, o_oc_warn_status, o_ot_fault_status;
  logic        o_alert_line_n_out, o_alert_line_n_oe;
  int          miscompares = 0;
  int          total_checks = 0;
  int          n;
  row_t        rows[5] = '{'{8'h4A, 16'h0020, 16'h0020, 1'b0},
                           '{8'h4B, 16'h0010, 16'h0010, 1'b0},
                           '{8'h4C, 16'hABCD, 16'h00CD, 1'b0},
                           '{8'h4F, 16'h0050, 16'h0050, 1'b0},
                           '{8'h4D, 16'h5555, 16'h0000, 1'b1}};
  logic [15:0] rv[4] = '{16'h0000, 16'h0000, 16'h0000, 16'h7FFF};

  current_fault_response_ctrl #(.CONT_UNIT_CYCLES(24'(CU)), .RETRY_UNIT_CYCLES(24'(RU))) uut (.*);
  host_cmd_model host (.i_mclk(i_mclk), .o_wr(i_cmd_wr), .o_rd(i_cmd_rd), .o_code(i_cmd_code),
                       .o_wdata(i_cmd_wdata), .o_clr(i_clear_faults));

  always #10 i_mclk = ~i_mclk;

  task chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task bit_is(input logic s, input logic e);
    chk({15'h0000, s}, {15'h0000, e});
  endtask : bit_is
  task tally_and_finish();
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task cyc(input int k);
    repeat (k) @(negedge i_mclk);
  endtask : cyc
  task reset_dut();
    i_rst = 1'b1;
    cyc(10);
    i_rst = 1'b0;
    cyc(5);
  endtask : reset_dut
  task meas(input logic [15:0] a, input logic [15:0] t);
    @(negedge i_mclk);
    i_meas_valid = 1'b1;
    i_iout_meas = a;
    i_temp_meas = t;
    @(negedge i_mclk);
    i_meas_valid = 1'b0;
  endtask : meas
  task wait_en(output int k);
    k = 0;
    while (o_output_enable !== 1'b1 && k < 40) begin
      @(negedge i_mclk);
      k++;
    end
  endtask : wait_en

  initial begin
    repeat (5000) @(posedge i_mclk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    reset_dut();
    foreach (rows[i]) begin
      host.xfer(1'b1, 1'b0, rows[i].c, rows[i].d);
      host.xfer(1'b0, 1'b1, rows[i].c, 16'h0000);
      chk(o_cmd_rdata, rows[i].q);
      bit_is(o_cmd_nack, rows[i].n);
    end
    reset_dut();
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b0, 1'b1, rows[i].c, 16'h0000);
      chk(o_cmd_rdata, rv[i]);
    end
    host.xfer(1'b1, 1'b0, 8'h4B, 16'h0010);
    meas(16'h0008, 16'h0000);
    bit_is(o_uc_fault_status, 1'b1);
    bit_is(o_alert_line_n_oe, 1'b1);
    bit_is(o_output_enable, 1'b1);
    host.clear();
    bit_is(o_uc_fault_status, 1'b0);
    host.xfer(1'b1, 1'b0, 8'h4A, 16'h0020);
    host.xfer(1'b1, 1'b0, 8'h4F, 16'h0050);
    meas(16'h0030, 16'h0060);
    bit_is(o_oc_warn_status, 1'b1);
    bit_is(o_ot_fault_status, 1'b1);
    host.clear();
    host.xfer(1'b1, 1'b0, 8'h4C, 16'h0089);
    meas(16'h0008, 16'h0000);
    bit_is(o_output_enable, 1'b0);
    wait_en(n);
    bit_is(n >= RU - 1 && n <= RU + 4, 1'b1);
    meas(16'h0008, 16'h0000);
    cyc(30);
    bit_is(o_output_enable, 1'b0);
    host.clear();
    cyc(3);
    bit_is(o_output_enable, 1'b1);
    host.xfer(1'b1, 1'b0, 8'h4C, 16'h0080);
    meas(16'h0008, 16'h0000);
    cyc(30);
    bit_is(o_output_enable, 1'b0);
    host.clear();
    cyc(3);
    host.xfer(1'b1, 1'b0, 8'h4C, 16'h00B9);
    repeat (3) begin
      meas(16'h0008, 16'h0000);
      wait_en(n);
      bit_is(n >= RU - 1 && n <= RU + 4, 1'b1);
    end
    i_other_fault_shutdown = 1'b1;
    cyc(1);
    i_other_fault_shutdown = 1'b0;
    cyc(2);
    bit_is(o_output_enable, 1'b0);
    i_operation_on = 1'b0;
    cyc(2);
    i_operation_on = 1'b1;
    cyc(3);
    bit_is(o_output_enable, 1'b1);
    bit_is(o_uc_fault_status, 1'b0);
    host.xfer(1'b1, 1'b0, 8'h4C, 16'h00C0);
    meas(16'h0008, 16'h0000);
    bit_is(o_output_enable, 1'b0);
    meas(16'h0020, 16'h0000);
    cyc(1);
    bit_is(o_output_enable, 1'b1);
    host.clear();
    host.xfer(1'b1, 1'b0, 8'h4C, 16'h0041);
    meas(16'h0008, 16'h0000);
    cyc(CU / 2);
    bit_is(o_output_enable, 1'b1);
    cyc(CU + 5);
    bit_is(o_output_enable, 1'b0);
    i_ctrl_pin = 1'b0;
    cyc(5);
    i_ctrl_pin = 1'b1;
    cyc(6);
    bit_is(o_output_enable, 1'b1);
    host.xfer(1'b1, 1'b0, 8'h4C, 16'h0042);
    meas(16'h0008, 16'h0000);
    cyc(2 * CU - 1);
    bit_is(o_output_enable, 1'b1);
    cyc(3);
    bit_is(o_output_enable, 1'b0);
    tally_and_finish();
  end
endmodule : current_fault_response_ctrl_tb_top
